// ---- core/pax_decode.sv ----
`timescale 1ns/100ps
`include "pax_defines.svh"
module pax_decode
  import pax_pkg::*;
(
  // Instruction
  input wire logic [15:0] opcode_in,
  input wire logic ext_enable_in,
  // Decoded
  output pax_pkg::pax_op_t op_out,
  output logic [1:0] sel_out,
  output logic [5:0] lit_out
);
  always_comb begin
    op_out = PAX_OP_NONE;
    sel_out = opcode_in[`PAX_SEL_MSB:`PAX_SEL_LSB];
    lit_out = opcode_in[`PAX_LIT_MSB:0];
    if (ext_enable_in) begin // RULE12
      if (opcode_in[15:8] == `PAX_ADD_OPHI) begin
        if (sel_out == `PAX_SEL_RET) begin
          op_out = PAX_OP_ADDRET; // RULE2
        end else begin
          op_out = PAX_OP_ADDPTR; // RULE1
        end
      end else if (opcode_in == `PAX_CALL_THROUGH_WORKING_REG_OP) begin
        op_out = PAX_OP_CALL_THROUGH_WORKING_REG; // RULE6
      end
    end
  end
endmodule

// ---- core/pax_defines.svh ----
// Operation
// RULE1 - Opcode E8 with select 0..2 adds 6-bit literal to that pointer, one cycle
// RULE2 - Select bits 11 make the opcode add-to-pointer-two-and-return
// RULE3 - Add-and-return adds the literal to pointer two and stores it there
// RULE4 - Add-and-return then loads the program counter from the return stack top
// RULE5 - Add-and-return takes two cycles, second is a no-operation, no flags change
// RULE6 - Opcode 0014 decodes as call through working register, no operands or flags
// RULE7 - Call first pushes program counter plus 2 onto the return stack
// RULE8 - Call then overwrites pc low byte with the working register
// RULE9 - Call copies high latch to pc bits 15:8 and upper latch to upper byte
// RULE10 - Call takes two cycles, second is a no-operation while target is fetched
// RULE11 - Call never shadow-saves working register, flags or bank select register
// RULE12 - Extended opcodes are recognised only when the extension enable is set
// RULE13 - Literal is zero-extended and pointer sums wrap, carry discarded
`ifndef PAX_DEFINES_SVH
`define PAX_DEFINES_SVH
`define PAX_ADD_OPHI 8'he8
`define PAX_CALL_THROUGH_WORKING_REG_OP 16'h0014
`define PAX_SEL_MSB 7
`define PAX_SEL_LSB 6
`define PAX_LIT_MSB 5
`define PAX_SEL_RET 2'h3
`define PAX_PC_STEP 21'h000002
`define PAX_PTR_RST 12'h000
`define PAX_PC_RST 21'h000000
`define PAX_STACK_DEPTH 31
`endif

// ---- core/pax_exec.sv ----
`timescale 1ns/100ps
`include "pax_defines.svh"
module pax_exec
  import pax_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Instruction stream
  input wire logic instr_valid_in,
  input wire logic [15:0] opcode_in,
  input wire logic ext_enable_in,
  // Core state read in
  input wire logic [7:0] wreg_in,
  input wire logic [7:0] pc_high_latch_in,
  input wire logic [4:0] pc_upper_latch_in,
  // Results
  output pax_pkg::pax_ptr_t ptr0_out,
  output pax_pkg::pax_ptr_t ptr1_out,
  output pax_pkg::pax_ptr_t pointer_two_out,
  output pax_pkg::pax_pc_t pc_out,
  output pax_pkg::pax_pc_t return_stack_top_out,
  output logic busy_out,
  output logic flags_write_out,
  output logic shadow_save_out
);
  pax_op_t op;
  logic [1:0] sel;
  logic [5:0] lit;
  pax_ptr_t ptr [3];
  pax_ptr_t next_ptr [3];
  pax_pc_t pc;
  pax_pc_t next_pc;
  pax_state_t state;
  pax_state_t next_state;
  logic push;
  logic pop;
  pax_pc_t stack_top;
  logic take;

  function automatic pax_ptr_t add_lit(input pax_ptr_t p, input logic [5:0] k);
    add_lit = p + {6'h00, k}; // RULE13
  endfunction

  pax_decode u_dec (
    .opcode_in(opcode_in),
    .ext_enable_in(ext_enable_in),
    .op_out(op),
    .sel_out(sel),
    .lit_out(lit)
  );

  pax_stack u_stack (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .push_in(push),
    .pop_in(pop),
    .push_data_in(pc + `PAX_PC_STEP),
    .top_out(stack_top)
  );

  // Opcodes arriving during the second cycle are the flushed fetch and are ignored
  assign take = instr_valid_in && (state == PAX_ST_EXEC);

  always_comb begin
    next_state = state;
    next_pc = pc;
    push = 1'b0;
    pop = 1'b0;
    for (int i = 0; i < 3; i++) begin
      next_ptr[i] = ptr[i];
    end
    case (state)
      PAX_ST_EXEC: begin
        if (take) begin
          next_pc = pc + `PAX_PC_STEP;
          case (op)
            PAX_OP_ADDPTR: begin
              next_ptr[sel] = add_lit(ptr[sel], lit); // RULE1
            end
            PAX_OP_ADDRET: begin
              next_ptr[2] = add_lit(ptr[2], lit); // RULE3
              next_pc = stack_top; // RULE4
              pop = 1'b1;
              next_state = PAX_ST_NOP; // RULE5
            end
            PAX_OP_CALL_THROUGH_WORKING_REG: begin
              push = 1'b1; // RULE7
              next_pc = {pc_upper_latch_in, pc_high_latch_in, wreg_in}; // RULE8 RULE9
              next_state = PAX_ST_NOP; // RULE10
            end
            default: begin
            end
          endcase
        end
      end
      PAX_ST_NOP: begin
        next_state = PAX_ST_EXEC;
      end
      default: begin
        next_state = PAX_ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state <= PAX_ST_EXEC;
      pc <= `PAX_PC_RST;
      for (int i = 0; i < 3; i++) begin
        ptr[i] <= `PAX_PTR_RST;
      end
    end else begin
      state <= next_state;
      pc <= next_pc;
      for (int i = 0; i < 3; i++) begin
        ptr[i] <= next_ptr[i];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ptr0_out <= `PAX_PTR_RST;
      ptr1_out <= `PAX_PTR_RST;
      pointer_two_out <= `PAX_PTR_RST;
      pc_out <= `PAX_PC_RST;
      return_stack_top_out <= `PAX_PC_RST;
      busy_out <= 1'b0;
      flags_write_out <= 1'b0;
      shadow_save_out <= 1'b0;
    end else begin
      ptr0_out <= next_ptr[0];
      ptr1_out <= next_ptr[1];
      pointer_two_out <= next_ptr[2];
      pc_out <= next_pc;
      return_stack_top_out <= stack_top;
      busy_out <= (next_state == PAX_ST_NOP);
      flags_write_out <= 1'b0; // RULE5
      shadow_save_out <= 1'b0; // RULE11
    end
  end

  sequence s_call_through_working_reg_taken;
    take && op == PAX_OP_CALL_THROUGH_WORKING_REG;
  endsequence
  sequence s_addret_taken;
    take && op == PAX_OP_ADDRET;
  endsequence

  AST_ADDPTR_SUM: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE1
    take && op == PAX_OP_ADDPTR |=> ptr[$past(sel)] == $past(ptr[sel]) + $past({6'h00, lit}))
    else $error("pointer add result wrong");
  AST_ADDRET_PTR2: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE3
    s_addret_taken |=> ptr[2] == $past(ptr[2]) + $past({6'h00, lit}))
    else $error("pointer two add wrong");
  AST_ADDRET_PC: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE4
    s_addret_taken |=> pc == $past(stack_top))
    else $error("return did not load stack top");
  AST_ADDRET_NOP: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE5
    s_addret_taken |=> state == PAX_ST_NOP ##1 state == PAX_ST_EXEC)
    else $error("add-and-return not two cycles");
  AST_CALL_THROUGH_WORKING_REG_PC: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE9
    s_call_through_working_reg_taken |=> pc == {$past(pc_upper_latch_in), $past(pc_high_latch_in), $past(wreg_in)})
    else $error("call target wrong");
  AST_CALL_THROUGH_WORKING_REG_LOW: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE8
    s_call_through_working_reg_taken |=> pc[7:0] == $past(wreg_in))
    else $error("call low byte not from working register");
  AST_CALL_THROUGH_WORKING_REG_PUSH: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE7
    s_call_through_working_reg_taken ##1 1'b1 |-> stack_top == $past(pc) + `PAX_PC_STEP)
    else $error("return address not pushed");
  AST_CALL_THROUGH_WORKING_REG_NOP: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE10
    s_call_through_working_reg_taken |=> busy_out && pc == $past(next_pc) ##1 !busy_out && pc == $past(pc))
    else $error("call second cycle not idle");
  AST_EXT_OFF: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE12
    !ext_enable_in |-> op == PAX_OP_NONE)
    else $error("extension decoded while disabled");
  AST_NO_SHADOW: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE11
    !shadow_save_out && !flags_write_out)
    else $error("flags or shadow touched");
endmodule

// ---- core/pax_pkg.sv ----
package pax_pkg;
  typedef logic [11:0] pax_ptr_t;
  typedef logic [20:0] pax_pc_t;
  typedef enum logic [1:0] {PAX_OP_NONE, PAX_OP_ADDPTR, PAX_OP_ADDRET, PAX_OP_CALL_THROUGH_WORKING_REG} pax_op_t;
  typedef enum {PAX_ST_EXEC, PAX_ST_NOP} pax_state_t;
endpackage

// ---- core/pax_stack.sv ----
`timescale 1ns/100ps
`include "pax_defines.svh"
module pax_stack
  import pax_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Operations
  input wire logic push_in,
  input wire logic pop_in,
  input pax_pkg::pax_pc_t push_data_in,
  // Top
  output pax_pkg::pax_pc_t top_out
);
  pax_pc_t mem [`PAX_STACK_DEPTH];
  logic [4:0] depth;
  logic [4:0] next_depth;
  // Wraps silently on overflow and underflow; no stack status is kept here.
  // The index wraps at the array size, so no slot outside the array is addressed.
  always_comb begin
    next_depth = depth;
    if (push_in) begin
      next_depth = (depth == 5'h1e) ? 5'h00 : depth + 5'h01;
    end else if (pop_in) begin
      next_depth = (depth == 5'h00) ? 5'h1e : depth - 5'h01;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      depth <= 5'h00;
    end else begin
      depth <= next_depth;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (push_in) begin
      mem[depth] <= push_data_in;
    end
  end
  assign top_out = mem[(depth == 5'h00) ? 5'h1e : depth - 5'h01];
endmodule

// ---- test/pointer_add_and_wreg_call_exec_tb.sv ----
`timescale 1ns/100ps
module pointer_add_and_wreg_call_exec_tb;
  import pax_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic instr_valid_in = 1'b0;
  logic [15:0] opcode_in = 16'h0000;
  logic ext_enable_in = 1'b0;
  logic [7:0] wreg_in = 8'h00;
  logic [7:0] pc_high_latch_in = 8'h00;
  logic [4:0] pc_upper_latch_in = 5'h00;
  pax_ptr_t ptr0_out, ptr1_out, pointer_two_out;
  pax_pc_t pc_out, return_stack_top_out;
  logic busy_out, flags_write_out, shadow_save_out;
  int n_fail = 0;
  int compares = 0;

  always #5 mclk_in = ~mclk_in;

  pax_exec u_pax_exec (.mclk_in(mclk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
    .opcode_in(opcode_in), .ext_enable_in(ext_enable_in), .wreg_in(wreg_in),
    .pc_high_latch_in(pc_high_latch_in), .pc_upper_latch_in(pc_upper_latch_in),
    .ptr0_out(ptr0_out), .ptr1_out(ptr1_out), .pointer_two_out(pointer_two_out),
    .pc_out(pc_out), .return_stack_top_out(return_stack_top_out), .busy_out(busy_out),
    .flags_write_out(flags_write_out), .shadow_save_out(shadow_save_out));

  task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Present one instruction for exactly one taking edge
  task automatic issue(input logic [15:0] op);
    @(posedge mclk_in);
    #1;
    opcode_in = op;
    instr_valid_in = 1'b1;
    @(posedge mclk_in);
    #1;
    instr_valid_in = 1'b0;
  endtask

  task automatic t_disabled();
    ext_enable_in = 1'b0;
    issue(16'he823);
    chk("ptr0", 21'(12'h000), 21'(ptr0_out));
    chk("pc", 21'h000002, pc_out);
    issue(16'he8e3);
    chk("ptr2", 21'(12'h000), 21'(pointer_two_out));
    chk("pc", 21'h000004, pc_out);
    issue(16'h0014);
    chk("pc", 21'h000006, pc_out);
    chk("busy", 21'(1'b0), 21'(busy_out));
    $display("test disabled done");
  endtask

  // A second opcode offered while busy must be ignored
  task automatic t_call();
    ext_enable_in = 1'b1;
    wreg_in = 8'h06;
    pc_high_latch_in = 8'h10;
    pc_upper_latch_in = 5'h01;
    issue(16'h0014);
    chk("pc", 21'h011006, pc_out);
    chk("busy", 21'(1'b1), 21'(busy_out));
    chk("shadow", 21'(1'b0), 21'(shadow_save_out));
    chk("flags", 21'(1'b0), 21'(flags_write_out));
    opcode_in = 16'he805;
    instr_valid_in = 1'b1;
    @(posedge mclk_in);
    #1;
    instr_valid_in = 1'b0;
    chk("busy", 21'(1'b0), 21'(busy_out));
    chk("ptr0", 21'(12'h000), 21'(ptr0_out));
    chk("pc", 21'h011006, pc_out);
    chk("stack top", 21'h000008, return_stack_top_out);
    $display("test call done");
  endtask

  task automatic t_add();
    issue(16'he823);
    chk("ptr0", 21'(12'h023), 21'(ptr0_out));
    chk("ptr1", 21'(12'h000), 21'(ptr1_out));
    chk("flags", 21'(1'b0), 21'(flags_write_out));
    chk("busy", 21'(1'b0), 21'(busy_out));
    issue(16'he8bf);
    chk("ptr2", 21'(12'h03f), 21'(pointer_two_out));
    for (int i = 0; i < 65; i++) begin
      issue(16'he87f);
    end
    chk("ptr1", 21'(12'hfff), 21'(ptr1_out));
    issue(16'he841);
    chk("ptr1", 21'(12'h000), 21'(ptr1_out));
    chk("ptr0", 21'(12'h023), 21'(ptr0_out));
    $display("test add done");
  endtask

  task automatic t_add_return();
    issue(16'he8e3);
    chk("ptr2", 21'(12'h062), 21'(pointer_two_out));
    chk("pc", 21'h000008, pc_out);
    chk("busy", 21'(1'b1), 21'(busy_out));
    chk("ptr0", 21'(12'h023), 21'(ptr0_out));
    chk("ptr1", 21'(12'h000), 21'(ptr1_out));
    @(posedge mclk_in);
    #1;
    chk("busy", 21'(1'b0), 21'(busy_out));
    chk("flags", 21'(1'b0), 21'(flags_write_out));
    $display("test add return done");
  endtask

  task automatic wrap_up();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge mclk_in);
    #1;
    rst_in = 1'b0;
    chk("pc", 21'h000000, pc_out);
    chk("ptr2", 21'(12'h000), 21'(pointer_two_out));
    chk("busy", 21'(1'b0), 21'(busy_out));
    $display("test reset done");
    t_disabled();
    t_call();
    t_add();
    t_add_return();
    wrap_up();
  end
endmodule
